/* ciu_dev.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - address and data share one bus
// - address strobe marks the address phase
// - each transfer ends on memory acknowledge
// - grant bus to external DMA master
// - four-deep store queue, issued in order
// - stores accepted each cycle while space
// - single-word and four-word reads supported
// - quad read per-word or burst acknowledges
// - parity generated on each refill word
// - read words buffered before cache fill
// - optional half-rate bus operation
// - optional longer read-to-write turnaround
// - snooped DMA writes invalidate cached lines
// - quad read fills one 16-byte line
module ciu_dev
  import ciu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  ciu_bus_if.dev                 bus,
  input  wire logic              st_valid,
  output logic                   st_ready,
  input  wire logic [DATA_W-1:0] st_addr,
  input  wire logic [DATA_W-1:0] st_data,
  input  wire logic              rd_req,
  input  wire logic [DATA_W-1:0] rd_addr,
  input  wire logic              rd_quad,
  input  wire logic              rd_burst,
  output logic                   rd_taken,
  output logic                   fill_valid,
  output logic      [DATA_W-1:0] fill_data,
  output logic      [PAR_W-1:0]  fill_par,
  output logic                   fill_last,
  output logic                   inv_valid,
  output logic      [DATA_W-1:0] inv_addr,
  input  wire logic              half_rate,
  input  wire logic              slow_turn
);
  typedef enum logic [2:0] {
    D_IDLE, D_WADDR, D_WDATA, D_RADDR, D_RDATA, D_TURN, D_FILL, D_DMA
  } ciu_dev_st_type;

  typedef struct packed {
    ciu_dev_st_type              st;
    logic [DATA_W-1:0]           ad;
    logic                        ad_oe;
    logic                        ale;
    logic                        rd;
    logic                        wr;
    logic                        quad;
    logic                        burst;
    logic                        gnt;
    logic                        tick;
    logic                        last_rd;
    logic [2:0]                  cnt;
    logic [1:0]                  widx;
    logic [1:0]                  fidx;
    logic [DATA_W-1:0]           wdat;
    logic [LINE_WORDS-1:0][DATA_W-1:0] rbuf;
    logic                        taken;
    logic                        fvalid;
    logic [DATA_W-1:0]           fdata;
    logic [PAR_W-1:0]            fpar;
    logic                        flast;
    logic                        ivalid;
    logic [DATA_W-1:0]           iaddr;
  } ciu_dev_state_type;

  ciu_dev_state_type     s_reg, s_next;
  logic                  wq_valid, wq_ready, en;
  logic [2*DATA_W-1:0]   wq_data;

  // even parity, one bit per byte lane
  function automatic logic [PAR_W-1:0] byte_par(input logic [DATA_W-1:0] w);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < PAR_W; i++) begin
      p[i] = ^w[8*i +: 8];
    end
    return p;
  endfunction

  // queue depth is the store buffer's own, so in_ready is the store stall
  ciu_fifo #(.WIDTH(2*DATA_W), .DEPTH(WQ_DEPTH)) u_wq (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (st_valid),
    .in_ready  (st_ready),
    .in_data   ({st_addr, st_data}),
    .out_valid (wq_valid),
    .out_ready (wq_ready),
    .out_data  (wq_data)
  );

  // idle and address phases advance only on every other edge in half-rate mode
  assign en = !half_rate || s_reg.tick;
  assign wq_ready = (s_reg.st == D_IDLE) && en && !bus.busreq && wq_valid
                    && !(s_reg.last_rd && slow_turn);

  always_comb begin
    s_next        = s_reg;
    s_next.tick   = !s_reg.tick;
    s_next.taken  = 1'b0;
    s_next.fvalid = 1'b0;
    s_next.flast  = 1'b0;
    s_next.ivalid = 1'b0;
    unique case (s_reg.st)
      D_IDLE: begin
        if (en) begin
          if (bus.busreq) begin
            s_next.gnt = 1'b1;
            s_next.st  = D_DMA;
          end else if (wq_valid) begin
            if (s_reg.last_rd && slow_turn) begin
              s_next.last_rd = 1'b0;
              s_next.cnt     = 3'(TURN_CYC);
              s_next.st      = D_TURN;
            end else begin
              s_next.ad    = wq_data[2*DATA_W-1:DATA_W];
              s_next.wdat  = wq_data[DATA_W-1:0];
              s_next.ad_oe = 1'b1;
              s_next.ale   = 1'b1;
              s_next.quad  = 1'b0;
              s_next.burst = 1'b0;
              s_next.st    = D_WADDR;
            end
          end else if (rd_req) begin
            // reads wait for the store queue to drain so none goes stale
            s_next.ad    = rd_addr;
            s_next.ad_oe = 1'b1;
            s_next.ale   = 1'b1;
            s_next.quad  = rd_quad;
            s_next.burst = rd_quad && rd_burst;
            s_next.widx  = '0;
            s_next.taken = 1'b1;
            s_next.st    = D_RADDR;
          end
        end
      end
      D_WADDR: begin
        if (en) begin
          s_next.ale = 1'b0;
          s_next.ad  = s_reg.wdat;
          s_next.wr  = 1'b1;
          s_next.st  = D_WDATA;
        end
      end
      D_WDATA: begin
        if (bus.ack) begin
          s_next.wr      = 1'b0;
          s_next.ad_oe   = 1'b0;
          s_next.last_rd = 1'b0;
          s_next.st      = D_IDLE;
        end
      end
      D_RADDR: begin
        if (en) begin
          s_next.ale   = 1'b0;
          s_next.ad_oe = 1'b0;
          s_next.rd    = 1'b1;
          s_next.st    = D_RDATA;
        end
      end
      D_RDATA: begin
        // acks counted every edge so a burst returns one word per clock
        if (bus.ack) begin
          s_next.rbuf[s_reg.widx] = bus.ad;
          s_next.widx = s_reg.widx + 2'h1;
          if (!s_reg.quad || s_reg.widx == 2'(LINE_WORDS-1)) begin
            s_next.rd      = 1'b0;
            s_next.burst   = 1'b0;
            s_next.last_rd = 1'b1;
            s_next.fidx    = '0;
            s_next.st      = D_FILL;
          end
        end
      end
      D_TURN: begin
        if (s_reg.cnt == RST_CNT) begin
          s_next.st = D_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 3'h1;
        end
      end
      D_FILL: begin
        s_next.fvalid = 1'b1;
        s_next.fdata  = s_reg.rbuf[s_reg.fidx];
        s_next.fpar   = byte_par(s_reg.rbuf[s_reg.fidx]);
        s_next.fidx   = s_reg.fidx + 2'h1;
        if (!s_reg.quad || s_reg.fidx == 2'(LINE_WORDS-1)) begin
          s_next.flast = 1'b1;
          s_next.st    = D_IDLE;
        end
      end
      D_DMA: begin
        if (bus.snoop) begin
          s_next.ivalid = 1'b1;
          s_next.iaddr  = bus.ad;
        end
        if (!bus.busreq) begin
          s_next.gnt = 1'b0;
          s_next.st  = D_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg       <= '0;
      s_reg.st    <= D_IDLE;
      s_reg.ad    <= RST_WORD;
      s_reg.iaddr <= RST_WORD;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.dev_ad    = s_reg.ad;
  assign bus.dev_ad_oe = s_reg.ad_oe;
  assign bus.ale       = s_reg.ale;
  assign bus.rd        = s_reg.rd;
  assign bus.wr        = s_reg.wr;
  assign bus.quad      = s_reg.quad;
  assign bus.burst     = s_reg.burst;
  assign bus.busgnt    = s_reg.gnt;
  assign rd_taken      = s_reg.taken;
  assign fill_valid    = s_reg.fvalid;
  assign fill_data     = s_reg.fdata;
  assign fill_par      = s_reg.fpar;
  assign fill_last     = s_reg.flast;
  assign inv_valid     = s_reg.ivalid;
  assign inv_addr      = s_reg.iaddr;
endmodule
`default_nettype wire

/* ciu_pkg.sv */
package ciu_pkg;
  localparam int DATA_W     = 32;
  localparam int PAR_W      = 4;
  localparam int WQ_DEPTH   = 4;
  localparam int LINE_WORDS = 4;
  localparam int WORD_BYTES = 4;
  localparam int CLK_NS     = 25;
  localparam int TURN_NS    = 50;
  localparam int TURN_CYC   = (TURN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0]  RST_CNT  = 3'h0;
endpackage

/* ciu_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ciu_bus_if;
  import ciu_pkg::*;
  logic [DATA_W-1:0] dev_ad;
  logic              dev_ad_oe;
  logic [DATA_W-1:0] host_ad;
  logic              host_ad_oe;
  logic [DATA_W-1:0] ad;
  logic              ale;
  logic              rd;
  logic              wr;
  logic              quad;
  logic              burst;
  logic              ack;
  logic              busreq;
  logic              busgnt;
  logic              snoop;

  // shared pins resolved here; the parked bus reads zero
  assign ad = dev_ad_oe ? dev_ad : (host_ad_oe ? host_ad : '0);

  modport dev (
    output dev_ad, dev_ad_oe, ale, rd, wr, quad, burst, busgnt,
    input  ad, ack, busreq, snoop
  );
  modport host (
    output host_ad, host_ad_oe, ack, busreq, snoop,
    input  ad, ale, rd, wr, quad, burst, busgnt
  );
endinterface
`default_nettype wire

/* ciu_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module ciu_fifo
  import ciu_pkg::*;
#(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          rdy;
  } ciu_fifo_state_type;

  ciu_fifo_state_type s_reg, s_next;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               push, pop;

  // space flag kept in a flop so the stall leaves the end unglitched
  assign in_ready  = s_reg.rdy;
  assign out_valid = s_reg.cnt != '0;
  assign out_data  = mem[s_reg.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wp = (s_reg.wp == AW'(DEPTH-1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == AW'(DEPTH-1)) ? '0 : s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_next.rdy = s_next.cnt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg     <= '0;
      s_reg.rdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
    if (push) begin
      mem[s_reg.wp] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* ciu_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ciu_host
  import ciu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  ciu_bus_if.host                bus,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic      [DATA_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [DATA_W-1:0] mem_rdata,
  input  wire logic              dma_req,
  input  wire logic [DATA_W-1:0] dma_addr,
  input  wire logic [DATA_W-1:0] dma_data,
  output logic                   dma_done
);
  typedef enum logic [2:0] {
    H_IDLE, H_CMD, H_WMEM, H_RMEM, H_DMEM, H_DEND
  } ciu_host_st_type;

  typedef struct packed {
    ciu_host_st_type   st;
    logic [DATA_W-1:0] ad;
    logic              ad_oe;
    logic              ack;
    logic              busreq;
    logic              snoop;
    logic              req;
    logic              we;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        left;
    logic              done;
  } ciu_host_state_type;

  ciu_host_state_type s_reg, s_next;

  always_comb begin
    s_next       = s_reg;
    s_next.ack   = 1'b0;
    s_next.ad_oe = 1'b0;
    s_next.snoop = 1'b0;
    s_next.req   = 1'b0;
    s_next.done  = 1'b0;
    unique case (s_reg.st)
      H_IDLE: begin
        if (bus.ale) begin
          s_next.addr = bus.ad;
          s_next.st   = H_CMD;
        end else if (s_reg.busreq && bus.busgnt) begin
          s_next.ad    = dma_addr;
          s_next.ad_oe = 1'b1;
          s_next.snoop = 1'b1;
          s_next.req   = 1'b1;
          s_next.we    = 1'b1;
          s_next.addr  = dma_addr;
          s_next.wdata = dma_data;
          s_next.st    = H_DMEM;
        end else if (dma_req && !s_reg.busreq) begin
          s_next.busreq = 1'b1;
        end
      end
      H_CMD: begin
        if (bus.wr) begin
          s_next.req   = 1'b1;
          s_next.we    = 1'b1;
          s_next.wdata = bus.ad;
          s_next.st    = H_WMEM;
        end else if (bus.rd) begin
          s_next.req  = 1'b1;
          s_next.we   = 1'b0;
          s_next.left = bus.quad ? 2'(LINE_WORDS-1) : 2'h0;
          s_next.st   = H_RMEM;
        end
      end
      H_WMEM: begin
        if (mem_ack) begin
          s_next.ack = 1'b1;
          s_next.st  = H_IDLE;
        end
      end
      H_RMEM: begin
        if (mem_ack) begin
          s_next.ad    = mem_rdata;
          s_next.ad_oe = 1'b1;
          s_next.ack   = 1'b1;
          if (s_reg.left == 2'h0) begin
            s_next.st = H_IDLE;
          end else begin
            s_next.left = s_reg.left - 2'h1;
            s_next.addr = s_reg.addr + DATA_W'(WORD_BYTES);
            s_next.req  = 1'b1;
          end
        end
      end
      H_DMEM: begin
        s_next.ad_oe = 1'b1;
        if (mem_ack) begin
          s_next.ad_oe  = 1'b0;
          s_next.busreq = 1'b0;
          s_next.done   = 1'b1;
          s_next.st     = H_DEND;
        end
      end
      H_DEND: begin
        if (!bus.busgnt) begin
          s_next.st = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg    <= '0;
      s_reg.st <= H_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.host_ad    = s_reg.ad;
  assign bus.host_ad_oe = s_reg.ad_oe;
  assign bus.ack        = s_reg.ack;
  assign bus.busreq     = s_reg.busreq;
  assign bus.snoop      = s_reg.snoop;
  assign mem_req        = s_reg.req;
  assign mem_we         = s_reg.we;
  assign mem_addr       = s_reg.addr;
  assign mem_wdata      = s_reg.wdata;
  assign dma_done       = s_reg.done;
endmodule
`default_nettype wire

/* ciu_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ciu_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dev_ad_oe,
  input wire logic host_ad_oe,
  input wire logic ale,
  input wire logic rd,
  input wire logic wr,
  input wire logic quad,
  input wire logic burst,
  input wire logic ack,
  input wire logic busreq,
  input wire logic busgnt,
  input wire logic snoop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  one_driver_a: assert property (!(dev_ad_oe && host_ad_oe))
    else $error("both ends drive ad");
  strobe_drive_a: assert property (ale |-> dev_ad_oe && !rd && !wr)
    else $error("ale without address phase");
  strobe_len_a: assert property ($rose(ale) |=> ##[0:1] !ale)
    else $error("ale too long");
  rw_excl_a: assert property (!(rd && wr))
    else $error("rd and wr together");
  wr_hold_a: assert property (wr && !ack |=> wr)
    else $error("wr dropped before ack");
  wr_end_a: assert property (wr && ack |=> ##[0:2] !wr)
    else $error("wr held after ack");
  rd_hold_a: assert property (rd && !ack |=> rd)
    else $error("rd dropped before ack");
  ack_owner_a: assert property (ack |-> rd || wr)
    else $error("ack outside transfer");
  burst_quad_a: assert property (burst |-> quad)
    else $error("burst on single read");
  grant_quiet_a: assert property (busgnt |-> !ale && !dev_ad_oe)
    else $error("device drives during grant");
  grant_cause_a: assert property ($rose(busgnt) |-> $past(busreq))
    else $error("grant without request");
  grant_drop_a: assert property (busgnt && !busreq |=> !busgnt)
    else $error("grant kept after release");
  snoop_grant_a: assert property (snoop |-> busgnt)
    else $error("snoop outside grant");
endmodule
`default_nettype wire

/* ciu_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ciu_test;
  import ciu_pkg::*;
  logic              clk, rstn, st_valid, st_ready, rd_req, rd_quad, rd_burst;
  logic              rd_taken, fill_valid, fill_last, inv_valid, half_rate, slow_turn;
  logic              mem_req, mem_we, mem_ack, dma_req, dma_done, pend, ale_q, saw_full;
  logic [DATA_W-1:0] st_addr, st_data, rd_addr, fill_data, inv_addr, inv_seen;
  logic [DATA_W-1:0] mem_addr, mem_wdata, mem_rdata, dma_addr, dma_data, a0;
  logic [PAR_W-1:0]  fill_par;
  logic [63:0]       wq [$];
  logic [31:0]       aq [$];
  int                mismatches;
  int                n_tests;
  int                cyc, t_fill, t_ale, gap;

  ciu_bus_if i_ciu_bus_if ();
  ciu_dev i_ciu_dev (.clk, .rstn, .bus(i_ciu_bus_if), .st_valid, .st_ready, .st_addr, .st_data,
    .rd_req, .rd_addr, .rd_quad, .rd_burst, .rd_taken, .fill_valid, .fill_data, .fill_par,
    .fill_last, .inv_valid, .inv_addr, .half_rate, .slow_turn);
  ciu_host i_ciu_host (.clk, .rstn, .bus(i_ciu_bus_if), .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .dma_req, .dma_addr, .dma_data, .dma_done);
  ciu_checker i_ciu_checker (.clk, .rstn, .dev_ad_oe(i_ciu_bus_if.dev_ad_oe),
    .host_ad_oe(i_ciu_bus_if.host_ad_oe), .ale(i_ciu_bus_if.ale), .rd(i_ciu_bus_if.rd),
    .wr(i_ciu_bus_if.wr), .quad(i_ciu_bus_if.quad), .burst(i_ciu_bus_if.burst),
    .ack(i_ciu_bus_if.ack), .busreq(i_ciu_bus_if.busreq), .busgnt(i_ciu_bus_if.busgnt),
    .snoop(i_ciu_bus_if.snoop));

  function automatic logic [31:0] mf(input logic [31:0] a);
    return a ^ 32'h5a5a_0000;
  endfunction
  function automatic logic [3:0] par(input logic [31:0] d);
    return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #2;
  endtask
  // valid left high so pushes run back to back; caller lowers it
  task automatic push(input logic [31:0] a, input logic [31:0] d);
    st_valid = 1'b1;
    st_addr = a;
    st_data = d;
    while (st_ready !== 1'b1) step();
    step();
  endtask
  task automatic rd_line(input logic [31:0] a, input logic q, input logic b);
    int n;
    int k;
    n = q ? LINE_WORDS : 1;
    k = 0;
    rd_req = 1'b1;
    rd_addr = a;
    rd_quad = q;
    rd_burst = b;
    while (rd_taken !== 1'b1) step();
    rd_req = 1'b0;
    while (k < n) begin
      step();
      if (fill_valid === 1'b1) begin
        a0 = mf(a + 32'(WORD_BYTES * k));
        chk("fill_data", a0, fill_data);
        chk("fill_par", 32'(par(a0)), 32'(fill_par));
        chk("fill_last", 32'(k == n - 1), 32'(fill_last));
        k++;
      end
    end
  endtask

  // memory side acks one cycle after each request
  always @(posedge clk) begin
    #2;
    mem_ack = pend;
    if (pend) mem_rdata = mf(mem_addr);
    pend = mem_req;
    if (mem_req === 1'b1 && mem_we === 1'b1) wq.push_back({mem_addr, mem_wdata});
    cyc++;
    if (fill_last === 1'b1) t_fill = cyc;
    if (i_ciu_bus_if.ale === 1'b1 && ale_q !== 1'b1) begin
      aq.push_back(i_ciu_bus_if.ad);
      t_ale = cyc;
    end
    ale_q = i_ciu_bus_if.ale;
    if (inv_valid === 1'b1) inv_seen = inv_addr;
    if (st_ready === 1'b0) saw_full = 1'b1;
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    {st_valid, rd_req, rd_quad, rd_burst, half_rate, slow_turn, mem_ack, dma_req} = '0;
    {st_addr, st_data, rd_addr, mem_rdata, dma_addr, dma_data} = '0;
    {pend, ale_q, saw_full, inv_seen} = '0;
    rstn = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    rstn = 1'b1;
    chk("st_ready", 32'h1, 32'(st_ready));
    for (int h = 0; h < 2; h++) begin
      half_rate = (h == 1);
      slow_turn = (h == 1);
      wq.delete();
      aq.delete();
      saw_full = 1'b0;
      for (int i = 0; i < 6; i++) push(32'h1000_0000 + 32'(4 * i), 32'ha5a5_0000 + 32'(i));
      st_valid = 1'b0;
      rd_line(32'h2000_0040, 1'b0, 1'b0);
      rd_line(32'h2000_0080, 1'b1, 1'b0);
      rd_line(32'h2000_00c0, 1'b1, 1'b1);
      push(32'h1000_0100, 32'hc3c3_0001);
      st_valid = 1'b0;
      for (int t = 0; t < 400 && wq.size() < 7; t++) step();
      chk("full_stall", 32'h1, 32'(saw_full));
      for (int i = 0; i < 6; i++) begin
        chk("wr_addr", 32'h1000_0000 + 32'(4 * i), wq[i][63:32]);
        chk("wr_data", 32'ha5a5_0000 + 32'(i), wq[i][31:0]);
        chk("ale_addr", 32'h1000_0000 + 32'(4 * i), aq[i]);
      end
      chk("ale_rd", 32'h2000_0040, aq[6]);
      chk("ale_quad", 32'h2000_00c0, aq[8]);
      chk("turn_wr", 32'hc3c3_0001, wq[6][31:0]);
      chk("turn_ale", 32'h1000_0100, aq[9]);
      // last fill to next address strobe; slow turnaround adds the wait plus entry and exit
      gap = t_ale - t_fill;
      chk("turn_gap", 32'h1, 32'(gap >= 2 + h * (TURN_CYC + 2) && gap <= 3 + h * (TURN_CYC + 2)));
      // a store still queued when the dma master asks for the bus
      push(32'h1000_0200, 32'h0f0f_0002);
      st_valid = 1'b0;
      dma_addr = 32'h3000_0010;
      dma_data = 32'h7e7e_0000;
      inv_seen = '0;
      dma_req = 1'b1;
      while (dma_done !== 1'b1) step();
      dma_req = 1'b0;
      for (int t = 0; t < 400 && wq.size() < 9; t++) step();
      chk("inv_addr", dma_addr, inv_seen);
      chk("queued_wr", 32'h0f0f_0002, (wq[7][31:0] == 32'h0f0f_0002) ? wq[7][31:0] : wq[8][31:0]);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
